// [hw/gpf_defs.svh]
// gpf_defs.svh: register offsets, field layout and reset values of the
// gpio pin function and direction block.
// assumes: included by bare name from the design files of this block.
`ifndef GPF_DEFS_SVH
`define GPF_DEFS_SVH

// ==========================================================================
// register byte offsets
`define GPF_OFS_FUNC      12'h418
`define GPF_OFS_DIR       12'h41C
`define GPF_OFS_DATA      12'h420

// ==========================================================================
// field layout and reset values
`define GPF_PIN_COUNT     16
`define GPF_RST_FUNC      16'h0000
`define GPF_RST_DIR       16'h0000
`define GPF_RST_OUT       16'h0000

`endif

// [hw/gpf_gpio_port.sv]
// gpf_gpio_port.sv: 16-pin gpio port with per-pin function select,
// direction and data registers behind an apb slave.
// assumes: one clock mclk, synchronous active-high reset, pad inputs and
// alternate-function signals already synchronous to mclk.
// limits: only strobes 1:0 matter, as bits 31:16 are not stored;
// unmapped offsets answer with pslverr and read as zero;
// a data write drops the bits of input and alternate pins, which
// keep their old stored value for when they become outputs;
// pads follow a register write one cycle after the register does.
//
// Notes on behaviour
// RL1: a one in a function-select bit hands that pin to its alternate use.
// RL2: a zero there makes it a gpio pin run by direction and data bits.
// RL3: a gpio pin whose direction bit is set is driven as an output.
// RL4: a gpio pin whose direction bit is clear is left undriven as an input.
// RL5: an alternate-function pin ignores its direction bit.
// RL6: a data read returns every pin's present level in either mode.
// RL7: writing the data register changes only gpio pins set as outputs.
// RL8: function select and direction reset to zero; bits 31:16 read 0.
`timescale 1ns/10ps
`default_nettype none
`include "gpf_defs.svh"

module gpf_gpio_port #(
    parameter int PINS = `GPF_PIN_COUNT
) (
    input  wire logic            mclk,
    input  wire logic            sys_rst,
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    input  wire logic [3:0]      pstrb,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    input  wire logic [PINS-1:0] padIn,
    output logic      [PINS-1:0] padOut,
    output logic      [PINS-1:0] padOe,
    input  wire logic [PINS-1:0] altOut,
    input  wire logic [PINS-1:0] altOe,
    output logic      [PINS-1:0] pinFunctionSelect
);
    // ======================================================================
    // address decode
    function automatic gpf_pkg::gpf_sel_e decode(input logic [11:0] a);
        unique case (a)
            `GPF_OFS_FUNC: decode = gpf_pkg::GPF_SEL_FUNC;
            `GPF_OFS_DIR:  decode = gpf_pkg::GPF_SEL_DIR;
            `GPF_OFS_DATA: decode = gpf_pkg::GPF_SEL_DATA;
            default:       decode = gpf_pkg::GPF_SEL_NONE;
        endcase
    endfunction

    // merge written bytes into a 16-bit field using the strobes
    // bytes 3:2 fall on the upper half, which is not stored, and are dropped
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
        merge = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction

    // ======================================================================
    // state
    // stored control registers
    logic [PINS-1:0] funcSel;
    logic [PINS-1:0] dirOut;
    logic [PINS-1:0] gpioOut;

    // next values of every flop group
    logic [PINS-1:0] next_funcSel;
    logic [PINS-1:0] next_dirOut;
    logic [PINS-1:0] next_gpioOut;
    logic [31:0]     next_prdata;
    logic            next_pready;
    logic            next_pslverr;
    logic [PINS-1:0] next_padOut;
    logic [PINS-1:0] next_padOe;
    logic [PINS-1:0] next_pinFunctionSelect;

    // pad path and bus helpers
    logic [PINS-1:0] muxOut;
    logic [PINS-1:0] muxOe;
    logic [15:0]     wrData;
    logic [PINS-1:0] padLevel;
    logic [PINS-1:0] gpioDrive;
    gpf_pkg::gpf_sel_e sel;
    logic            setup;
    logic            wrAccess;

    // decoded access phases and the mask of gpio pins set as outputs
    assign sel       = decode(paddr);
    assign setup     = psel & ~penable;
    assign wrAccess  = psel & penable & pready & pwrite;
    assign padLevel  = padIn;
    assign gpioDrive = ~funcSel & dirOut;

    // ======================================================================
    // bus answer
    // no wait state: the answer is registered in the setup cycle, so pready
    // is high in the first access cycle and prdata comes from a flop
    // prdata then holds until the next setup, for a master that reads late
    always_comb begin
        next_prdata  = prdata;
        next_pready  = 1'b0;
        next_pslverr = 1'b0;
        if (setup) begin
            next_pready  = 1'b1;
            // unmapped offsets answer with an error and read as zero
            next_pslverr = (sel == gpf_pkg::GPF_SEL_NONE);
            next_prdata  = 32'h0000_0000; // upper half reads zero (see RL8)
            if (!pwrite) begin
                unique case (sel)
                    gpf_pkg::GPF_SEL_FUNC: next_prdata[PINS-1:0] = funcSel;
                    gpf_pkg::GPF_SEL_DIR:  next_prdata[PINS-1:0] = dirOut;
                    // live pad level whatever the mode (see RL6)
                    gpf_pkg::GPF_SEL_DATA: next_prdata[PINS-1:0] = padLevel;
                    gpf_pkg::GPF_SEL_NONE: next_prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ======================================================================
    // register next values
    // writes take effect only at the edge that completes the access, so a
    // master that lingers in setup never moves a pin early
    always_comb begin
        next_funcSel = funcSel;
        next_dirOut  = dirOut;
        next_gpioOut = gpioOut;
        wrData       = 16'h0000;
        if (wrAccess) begin
            unique case (sel)
                gpf_pkg::GPF_SEL_FUNC: begin
                    wrData       = merge(16'(funcSel), pwdata, pstrb);
                    next_funcSel = wrData[PINS-1:0]; // see RL1, RL2
                end
                gpf_pkg::GPF_SEL_DIR: begin
                    wrData      = merge(16'(dirOut), pwdata, pstrb);
                    next_dirOut = wrData[PINS-1:0]; // see RL3, RL4
                end
                gpf_pkg::GPF_SEL_DATA: begin
                    wrData = merge(16'(gpioOut), pwdata, pstrb);
                    // only gpio-mode outputs take the new value; the rest
                    // keep their stored bit until they turn into outputs
                    next_gpioOut = (wrData[PINS-1:0] & gpioDrive)
                                 | (gpioOut & ~gpioDrive); // see RL7
                end
                gpf_pkg::GPF_SEL_NONE: wrData = 16'h0000;
            endcase
        end
    end

    // ======================================================================
    // bus answer flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= next_prdata;
            pready  <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ======================================================================
    // control register flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            funcSel <= PINS'(`GPF_RST_FUNC); // see RL8
            dirOut  <= PINS'(`GPF_RST_DIR);  // inputs after reset (see RL8)
            gpioOut <= PINS'(`GPF_RST_OUT);
        end else begin
            funcSel <= next_funcSel;
            dirOut  <= next_dirOut;
            gpioOut <= next_gpioOut;
        end
    end

    // ======================================================================
    // pad steering; muxed result is flopped so pad outputs come from flops
    gpf_pad_mux #(
        .PINS    (PINS)
    ) u_mux (
        .funcSel (funcSel),
        .dirOut  (dirOut),
        .gpioOut (gpioOut),
        .altOut  (altOut),
        .altOe   (altOe),
        .padOut  (muxOut),
        .padOe   (muxOe)
    );

    // ======================================================================
    // pad flops
    // pads and function select lag the registers by one cycle; the extra
    // flop costs a cycle of latency but keeps mux glitches off the pins
    always_comb begin
        next_padOut            = muxOut; // see RL3, RL5
        next_padOe             = muxOe;  // see RL4, RL5
        next_pinFunctionSelect = funcSel;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            padOut            <= '0;
            padOe             <= '0; // undriven in reset (see RL4)
            pinFunctionSelect <= '0;
        end else begin
            padOut            <= next_padOut;
            padOe             <= next_padOe;
            pinFunctionSelect <= next_pinFunctionSelect;
        end
    end
endmodule

`default_nettype wire

// [hw/gpf_pad_mux.sv]
// gpf_pad_mux.sv: per-pin steering between gpio logic and alternate function.
// assumes: all inputs come from flip-flops of the same mclk domain.
`timescale 1ns/10ps
`default_nettype none

module gpf_pad_mux #(
    parameter int PINS = 16
) (
    input  wire logic [PINS-1:0] funcSel,
    input  wire logic [PINS-1:0] dirOut,
    input  wire logic [PINS-1:0] gpioOut,
    input  wire logic [PINS-1:0] altOut,
    input  wire logic [PINS-1:0] altOe,
    output logic      [PINS-1:0] padOut,
    output logic      [PINS-1:0] padOe
);
    // ======================================================================
    // pin steering
    // alternate pins follow the alternate function alone (see RL1, RL5)
    // gpio pins drive only when set as outputs (see RL2, RL3, RL4)
    always_comb begin
        padOut = (funcSel & altOut) | (~funcSel & gpioOut);
        padOe  = (funcSel & altOe)  | (~funcSel & dirOut);
    end
endmodule

`default_nettype wire

// [hw/gpf_pkg.sv]
// gpf_pkg.sv: types shared by the gpio pin function and direction block.
// assumes: compiled before the design modules.
`default_nettype none

package gpf_pkg;
    // ======================================================================
    // register selected by an apb address
    typedef enum logic [3:0] {
        GPF_SEL_NONE = 4'b0001,
        GPF_SEL_FUNC = 4'b0010,
        GPF_SEL_DIR  = 4'b0100,
        GPF_SEL_DATA = 4'b1000
    } gpf_sel_e;
endpackage

`default_nettype wire

// [tb/gpf_gpio_port_test.sv]
// gpf_gpio_port_test.sv: directed apb test of the gpio port, with binding.
// assumes: gpf_defs.svh on the include path; design compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "gpf_defs.svh"
module gpf_gpio_port_test;
    logic        mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, rdy, err, qe;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rdat, q;
    logic [15:0] padIn = 16'h0000, padOut, padOe, fs;
    logic [15:0] altOut = 16'h1234, altOe = 16'h0F0F;
    int          badCount = 0, checked = 0;
    // ======================================================================
    // clock; answers copied at the falling edge, away from the flop updates
    always #50 mclk = ~mclk;
    always @(negedge mclk) begin
        rdy = pready;
        rdat = prdata;
        err = pslverr;
    end
    gpf_gpio_port u_gpf_gpio_port (.mclk(mclk), .sys_rst(sys_rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .padIn(padIn), .padOut(padOut), .padOe(padOe),
        .altOut(altOut), .altOe(altOe), .pinFunctionSelect(fs));
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer held until pready; an idle cycle follows the release
    task automatic xfer(input logic w, input logic [11:0] a, logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (rdy !== 1'b1 && n < 16);
        chk("pready", 32'(rdy), 32'h0000_0001);
        q = rdat;
        qe = err;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic pins(input logic [15:0] eOut, eOe, eFs);
        @(negedge mclk);
        chk("padOut", 32'(padOut), 32'(eOut));
        chk("padOe", 32'(padOe), 32'(eOe));
        chk("pinFunctionSelect", 32'(fs), 32'(eFs));
        @(posedge mclk);
    endtask
    task automatic tally_and_finish;
        $display("mismatches %0d in %0d compares", badCount, checked);
        if (badCount == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // watchdog: the sequence needs well under 200 cycles
    initial begin
        repeat (2000) @(posedge mclk);
        badCount++;
        tally_and_finish;
    end
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        xfer(0, `GPF_OFS_FUNC, 0);
        chk("func", q, 32'h0000_0000);
        pins(16'h0000, 16'h0000, 16'h0000);
        xfer(1, `GPF_OFS_DIR, 32'hFFFF_00F0);
        xfer(0, `GPF_OFS_DIR, 0);
        chk("dir", q, 32'h0000_00F0);
        pins(16'h0000, 16'h00F0, 16'h0000);
        xfer(1, `GPF_OFS_DATA, 32'h0000_A5A5);
        xfer(1, `GPF_OFS_DIR, 32'h0000_FFFF);
        pins(16'h00A0, 16'hFFFF, 16'h0000);
        xfer(1, `GPF_OFS_FUNC, 32'h0000_00FF);
        pins(16'h0034, 16'hFF0F, 16'h00FF);
        xfer(1, `GPF_OFS_DATA, 32'h0000_FFFF);
        pins(16'hFF34, 16'hFF0F, 16'h00FF);
        padIn <= 16'hBEEF;
        xfer(0, `GPF_OFS_DATA, 0);
        chk("data", q, 32'h0000_BEEF);
        xfer(1, `GPF_OFS_FUNC, 0);
        pins(16'hFFA0, 16'hFFFF, 16'h0000);
        xfer(1, `GPF_OFS_DIR, 0);
        pins(16'hFFA0, 16'h0000, 16'h0000);
        xfer(1, 12'h40C, 32'hFFFF_FFFF);
        chk("err", 32'(qe), 32'h0000_0001);
        xfer(0, 12'h40C, 0);
        chk("unmapped", q, 32'h0000_0000);
        chk("err rd", 32'(qe), 32'h0000_0001);
        // second reset with non-zero registers: everything must clear again
        xfer(1, `GPF_OFS_FUNC, 32'h0000_0F0F);
        xfer(1, `GPF_OFS_DIR, 32'h0000_00FF);
        pins(16'hF2A4, 16'h0FFF, 16'h0F0F);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        pins(16'h0000, 16'h0000, 16'h0000);
        xfer(0, `GPF_OFS_FUNC, 0);
        chk("func rst", q, 32'h0000_0000);
        xfer(0, `GPF_OFS_DIR, 0);
        chk("dir rst", q, 32'h0000_0000);
        xfer(1, `GPF_OFS_DIR, 32'h0000_FFFF);
        pins(16'h0000, 16'hFFFF, 16'h0000);
        tally_and_finish;
    end
endmodule
bind gpf_gpio_port gpf_port_assertions #(.PINS(PINS)) u_gpf_port_assertions (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .altOut(altOut), .altOe(altOe), .pinFunctionSelect(pinFunctionSelect));
`default_nettype wire

// [tb/gpf_port_assertions.sv]
// gpf_port_assertions.sv: concurrent checks on the gpio port pins and apb.
// assumes: bound to gpf_gpio_port; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module gpf_port_assertions #(
    parameter int PINS = 16
) (
    input wire logic            mclk,
    input wire logic            sys_rst,
    input wire logic            psel,
    input wire logic            penable,
    input wire logic            pwrite,
    input wire logic [11:0]     paddr,
    input wire logic [31:0]     pwdata,
    input wire logic [31:0]     prdata,
    input wire logic            pready,
    input wire logic [PINS-1:0] padIn,
    input wire logic [PINS-1:0] padOut,
    input wire logic [PINS-1:0] padOe,
    input wire logic [PINS-1:0] altOut,
    input wire logic [PINS-1:0] altOe,
    input wire logic [PINS-1:0] pinFunctionSelect
);
    // ======================================================================
    // decode once; pins lag a register write by two edges (reg, then pad)
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic            wrDone;
    logic            rdSet;
    logic [PINS-1:0] fs;
    logic [PINS-1:0] wd;
    assign wrDone = psel && penable && pready && pwrite;
    assign rdSet  = psel && !penable && !pwrite;
    assign fs     = pinFunctionSelect;
    assign wd     = pwdata[PINS-1:0];
    a_func_copy: assert property (wrDone && paddr == 12'h418 |-> ##2
        fs == $past(wd, 2)) else $error("function select copy wrong");
    a_alt_out: assert property (
        (padOut & fs) == ($past(altOut) & fs)) else $error("alt out lost");
    a_alt_oe: assert property (
        (padOe & fs) == ($past(altOe) & fs)) else $error("alt enable lost");
    a_dir_drive: assert property (wrDone && paddr == 12'h41C |-> ##2
        (padOe & ~fs) == ($past(wd, 2) & ~fs)) else $error("direction wrong");
    a_dir_input: assert property (wrDone && paddr == 12'h41C |-> ##2
        (padOe & ~fs & ~$past(wd, 2)) == '0) else $error("input driven");
    a_data_write: assert property (wrDone && paddr == 12'h420 |->
        ##2 ((padOut ^ $past(wd, 2)) & padOe & ~fs) == '0)
        else $error("data out");
    a_data_read: assert property (rdSet && paddr == 12'h420 |=>
        prdata == 32'($past(padIn))) else $error("pin level read wrong");
    a_reset_zero: assert property ($fell(sys_rst) |->
        padOe == '0 && padOut == '0 && fs == '0) else $error("reset state");
    c_func_wr: cover property (wrDone && paddr == 12'h418);
    c_data_rd: cover property (rdSet && paddr == 12'h420);
    c_alt_oe: cover property (|(padOe & fs));
endmodule
`default_nettype wire
